//--- src/cczm_pkg.sv
package cczm_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int LBA_W = 8;
	localparam int NLBA = 256;
	localparam int NZONE = 4;
	localparam int OFF_W = 6;
	localparam int WP_W = 7;
	localparam logic [OFF_W-1:0] OFF_LAST = 6'h3F;
	localparam logic [WP_W-1:0] WP_FULL = 7'h40;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_WPTR = 8'h0C;
	localparam logic [7:0] ADDR_ZSTATE = 8'h10;
	localparam logic [7:0] ADDR_HOLD = 8'h14;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int CTRL_WRE_BIT = 0;
	localparam int CTRL_MAXO_LSB = 4;
	localparam int CMD_FUA_BIT = 4;
	localparam int CMD_LBA_LSB = 8;
	localparam int STAT_UA_BIT = 5;
	localparam logic [3:0] MAXO_RST = 4'h2;
	localparam logic [15:0] HOLD_RST = 16'h0000;

	// ****************************************
	// commands, actions, zone conditions
	// ****************************************
	localparam logic [3:0] OP_HOST_WR = 4'h0;
	localparam logic [3:0] OP_INT_WR = 4'h1;
	localparam logic [3:0] OP_HOST_RD = 4'h2;
	localparam logic [3:0] OP_INT_RD = 4'h3;
	localparam logic [3:0] OP_VERIFY = 4'h4;
	localparam logic [3:0] OP_CLOSE = 4'h5;
	localparam logic [3:0] OP_FINISH = 4'h6;
	localparam logic [3:0] OP_MGMT = 4'h7;
	localparam logic [3:0] OP_OPEN = 4'h8;

	localparam logic [2:0] ACT_CACHE_WR = 3'h1;
	localparam logic [2:0] ACT_CACHE_RD = 3'h2;
	localparam logic [2:0] ACT_CACHE_INV = 3'h3;
	localparam logic [2:0] ACT_MED_WR = 3'h4;
	localparam logic [2:0] ACT_MED_RD = 3'h5;
	localparam logic [2:0] ACT_MED_VFY = 3'h6;

	localparam logic [2:0] ZC_EMPTY = 3'h0;
	localparam logic [2:0] ZC_IMP = 3'h1;
	localparam logic [2:0] ZC_EXP = 3'h2;
	localparam logic [2:0] ZC_CLOSED = 3'h3;
	localparam logic [2:0] ZC_FULL = 3'h4;

	// sense codes, arbitrary values
	localparam logic [7:0] ASC_DEGRADED = 8'h01;
	localparam logic [7:0] ASC_NOW_VOLATILE = 8'h02;
	localparam logic [7:0] ASC_NO_ZONE_RES = 8'h03;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_FLUSH = 4'b0010,
		ST_EXEC = 4'b0100,
		ST_MGMT = 4'b1000
	} cczm_state_type;

	typedef struct packed {
		cczm_state_type state;
		logic step;
		logic [3:0] op;
		logic fua;
		logic [LBA_W-1:0] lba;
		logic [1:0] zone;
		logic [OFF_W-1:0] fidx;
		logic [NLBA-1:0] valid;
		logic [NLBA-1:0] dirty;
		logic [NZONE-1:0][WP_W-1:0] wp;
		logic [NZONE-1:0][2:0] zst;
		logic wre;
		logic [3:0] maxo;
		logic [15:0] hold;
		logic done;
		logic abort;
		logic [7:0] ie_code;
		logic ie_valid;
		logic ua_pend;
		logic [7:0] ua_code;
		logic act_valid;
		logic [2:0] act_code;
		logic [LBA_W-1:0] act_lba;
		logic [31:0] prdata;
		logic deg_q;
		logic vol_q;
		logic boot;
	} cczm_regs_type;

	localparam cczm_regs_type REGS_RST = '{state: ST_IDLE, maxo: MAXO_RST, hold: HOLD_RST,
		default: '0};

endpackage : cczm_pkg

//--- src/cczm_top.sv
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module cczm_top
	import cczm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nonvolatile_cache_supported,
	input wire logic nv_power_degraded,
	input wire logic nv_cache_volatile,
	input wire logic power_loss_recover,
	output logic act_valid,
	output logic [2:0] act_code,
	output logic [7:0] act_lba,
	output logic ie_valid,
	output logic [7:0] ie_code,
	output logic ua_pending,
	output logic [7:0] ua_code,
	output logic busy
);

	cczm_regs_type s_q, s_d;

	// ****************************************
	// bus decode
	// ****************************************
	logic hit;
	logic wr_acc;
	logic rd_setup;

	always_comb begin
		hit = (paddr == ADDR_CTRL) || (paddr == ADDR_CMD) || (paddr == ADDR_STATUS) ||
			(paddr == ADDR_WPTR) || (paddr == ADDR_ZSTATE) || (paddr == ADDR_HOLD);
		wr_acc = psel && penable && pwrite && hit;
		rd_setup = psel && !penable && !pwrite;
	end


	// ****************************************
	// outputs
	// ****************************************
	assign pready = psel && penable;
	assign pslverr = psel && penable && !hit;
	assign prdata = s_q.prdata;
	assign act_valid = s_q.act_valid;
	assign act_code = s_q.act_code;
	assign act_lba = s_q.act_lba;
	assign ie_valid = s_q.ie_valid;
	assign ie_code = s_q.ie_code;
	assign ua_pending = s_q.ua_pend;
	assign ua_code = s_q.ua_code;
	assign busy = s_q.state != ST_IDLE;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [LBA_W-1:0] fl;
		logic [OFF_W-1:0] off;
		logic [1:0] zn;
		logic [2:0] xcnt;
		logic [2:0] ycnt;
		logic [1:0] sel;
		logic fin;
		logic bypass;
		logic deg_rise;
		logic vol_rise;
		fl = {s_q.zone, s_q.fidx};
		off = s_q.lba[OFF_W-1:0];
		zn = s_q.lba[LBA_W-1:OFF_W];
		xcnt = '0;
		ycnt = '0;
		sel = '0;
		fin = 1'b0;
		bypass = s_q.fua && s_q.vol_q;
		deg_rise = nv_power_degraded && !s_q.deg_q;
		vol_rise = nv_cache_volatile && !s_q.vol_q && s_q.boot;
		s_d = s_q;
		s_d.act_valid = 1'b0;
		s_d.ie_valid = 1'b0;
		s_d.deg_q = nv_power_degraded;
		s_d.vol_q = nv_cache_volatile;
		s_d.boot = 1'b1;

		// ****************************************
		// count open zones
		// ****************************************
		for (int i = NZONE - 1; i >= 0; i--) begin
			if (s_q.zst[i] == ZC_EXP) begin
				xcnt = xcnt + 3'h1;
			end
			if (s_q.zst[i] == ZC_IMP) begin
				ycnt = ycnt + 3'h1;
				sel = 2'(i);
			end
		end

		// ****************************************
		// register writes
		// ****************************************
		if (wr_acc) begin
			case (paddr)
				ADDR_CTRL: begin
					s_d.wre = pwdata[CTRL_WRE_BIT];
					s_d.maxo = pwdata[CTRL_MAXO_LSB +: 4];
				end
				ADDR_CMD: begin
					if (s_q.state == ST_IDLE) begin
						s_d.op = pwdata[3:0];
						s_d.fua = pwdata[CMD_FUA_BIT];
						s_d.lba = pwdata[CMD_LBA_LSB +: LBA_W];
						s_d.zone = pwdata[CMD_LBA_LSB + OFF_W +: 2];
						s_d.fidx = '0;
						s_d.step = 1'b0;
						s_d.done = 1'b0;
						s_d.abort = 1'b0;
						if ((pwdata[3:0] == OP_CLOSE) || (pwdata[3:0] == OP_FINISH)) begin
							s_d.state = ST_FLUSH;
						end else if (pwdata[CMD_FUA_BIT] && ((pwdata[3:0] == OP_HOST_WR) ||
							(pwdata[3:0] == OP_HOST_RD))) begin
							s_d.state = ST_FLUSH;
						end else if (pwdata[3:0] == OP_MGMT) begin
							s_d.state = ST_MGMT;
						end else begin
							s_d.state = ST_EXEC;
						end
					end
				end
				ADDR_STATUS: begin
					if (pwdata[STAT_UA_BIT]) begin
						s_d.ua_pend = 1'b0;
					end
				end
				ADDR_HOLD: begin
					s_d.hold = pwdata[15:0];
				end
				default: begin
				end
			endcase
		end

		// ****************************************
		// command engine
		// ****************************************
		case (s_q.state)
			ST_IDLE: begin
			end
			ST_FLUSH: begin
				if (s_q.dirty[fl]) begin
					s_d.act_valid = 1'b1;
					s_d.act_code = ACT_MED_WR;
					s_d.act_lba = fl;
					s_d.dirty[fl] = 1'b0;
				end
				s_d.fidx = s_q.fidx + 6'h01;
				if (s_q.fidx == OFF_LAST) begin
					s_d.state = ST_EXEC;
				end
			end
			ST_MGMT: begin
				if ({1'b0, xcnt} >= s_q.maxo) begin
					s_d.abort = 1'b1;
					s_d.ie_code = ASC_NO_ZONE_RES;
					fin = 1'b1;
				end else if (s_q.maxo > ({1'b0, xcnt} + {1'b0, ycnt})) begin
					fin = 1'b1;
				end else if (ycnt != 3'h0) begin
					s_d.zone = sel;
					s_d.lba = {sel, 6'h00};
					s_d.op = OP_CLOSE;
					s_d.state = ST_FLUSH;
				end else begin
					fin = 1'b1;
				end
			end
			ST_EXEC: begin
				s_d.act_valid = 1'b1;
				s_d.act_lba = s_q.lba;
				case (s_q.op)
					OP_HOST_WR: begin
						if (bypass && !s_q.step) begin
							s_d.act_code = ACT_CACHE_INV;
							s_d.valid[s_q.lba] = 1'b0;
							s_d.dirty[s_q.lba] = 1'b0;
							s_d.step = 1'b1;
						end else begin
							if (bypass) begin
								s_d.act_code = ACT_MED_WR;
							end else begin
								s_d.act_code = ACT_CACHE_WR;
								s_d.valid[s_q.lba] = 1'b1;
								s_d.dirty[s_q.lba] = 1'b1;
							end
							if (WP_W'(off) >= s_q.wp[zn]) begin
								s_d.wp[zn] = WP_W'(off) + 7'h01;
							end
							if ((s_q.zst[zn] == ZC_EMPTY) || (s_q.zst[zn] == ZC_CLOSED)) begin
								s_d.zst[zn] = ZC_IMP;
							end
							fin = 1'b1;
						end
					end
					OP_INT_WR: begin
						if (s_q.dirty[s_q.lba] && !s_q.step) begin
							s_d.act_code = ACT_CACHE_INV;
							s_d.valid[s_q.lba] = 1'b0;
							s_d.dirty[s_q.lba] = 1'b0;
							s_d.step = 1'b1;
						end else begin
							s_d.act_code = ACT_MED_WR;
							fin = 1'b1;
						end
					end
					OP_HOST_RD: begin
						if (s_q.valid[s_q.lba] && s_q.dirty[s_q.lba] && !bypass) begin
							s_d.act_code = ACT_CACHE_RD;
						end else begin
							s_d.act_code = ACT_MED_RD;
						end
						fin = 1'b1;
					end
					OP_INT_RD, OP_VERIFY: begin
						if (s_q.dirty[s_q.lba] && !s_q.step) begin
							s_d.act_code = ACT_MED_WR;
							s_d.dirty[s_q.lba] = 1'b0;
							s_d.step = 1'b1;
						end else begin
							s_d.act_code = (s_q.op == OP_VERIFY) ? ACT_MED_VFY : ACT_MED_RD;
							fin = 1'b1;
						end
					end
					OP_CLOSE: begin
						s_d.act_valid = 1'b0;
						if ((s_q.zst[s_q.zone] == ZC_IMP) || (s_q.zst[s_q.zone] == ZC_EXP)) begin
							s_d.zst[s_q.zone] = ZC_CLOSED;
						end
						fin = 1'b1;
					end
					OP_FINISH: begin
						s_d.act_valid = 1'b0;
						s_d.zst[s_q.zone] = ZC_FULL;
						s_d.wp[s_q.zone] = WP_FULL;
						fin = 1'b1;
					end
					OP_OPEN: begin
						s_d.act_valid = 1'b0;
						if (s_q.zst[s_q.zone] != ZC_FULL) begin
							s_d.zst[s_q.zone] = ZC_EXP;
						end
						fin = 1'b1;
					end
					default: begin
						s_d.act_valid = 1'b0;
						fin = 1'b1;
					end
				endcase
			end
			default: begin
				s_d.state = ST_IDLE;
			end
		endcase

		if (fin) begin
			s_d.state = ST_IDLE;
			s_d.done = 1'b1;
		end

		// ****************************************
		// unexpected power loss recovery
		// ****************************************
		if (power_loss_recover && s_q.vol_q) begin
			for (int i = 0; i < NLBA; i++) begin
				if (s_q.dirty[i]) begin
					s_d.valid[i] = 1'b0;
					s_d.dirty[i] = 1'b0;
					if (WP_W'(i % 64) < s_d.wp[i / 64]) begin
						s_d.wp[i / 64] = WP_W'(i % 64);
					end
				end
			end
			s_d.state = ST_IDLE;
		end

		// ****************************************
		// backing power events
		// ****************************************
		if (vol_rise || (nv_cache_volatile && s_q.vol_q)) begin
			s_d.hold = '0;
		end
		if (nonvolatile_cache_supported) begin
			if (deg_rise) begin
				if (s_q.wre) begin
					s_d.ie_valid = 1'b1;
					s_d.ie_code = ASC_DEGRADED;
				end else begin
					s_d.ua_pend = 1'b1;
					s_d.ua_code = ASC_DEGRADED;
				end
			end
			if (vol_rise) begin
				if (s_q.wre) begin
					s_d.ie_valid = 1'b1;
					s_d.ie_code = ASC_NOW_VOLATILE;
				end else begin
					s_d.ua_pend = 1'b1;
					s_d.ua_code = ASC_NOW_VOLATILE;
				end
			end
			if (!s_q.boot && nv_cache_volatile) begin
				s_d.ua_pend = 1'b1;
				s_d.ua_code = ASC_NOW_VOLATILE;
			end
		end

		// ****************************************
		// read data, sampled in the setup cycle
		// ****************************************
		if (rd_setup) begin
			case (paddr)
				ADDR_CTRL: s_d.prdata = {24'h000000, s_q.maxo, 3'h0, s_q.wre};
				ADDR_CMD: s_d.prdata = {16'h0000, s_q.lba, 3'h0, s_q.fua, s_q.op};
				ADDR_STATUS: s_d.prdata = {8'h00, s_q.ie_code, s_q.ua_code, 2'h0, s_q.ua_pend,
					s_q.deg_q, s_q.vol_q, s_q.abort, s_q.done, s_q.state != ST_IDLE};
				ADDR_WPTR: s_d.prdata = {1'b0, s_q.wp[3], 1'b0, s_q.wp[2], 1'b0, s_q.wp[1],
					1'b0, s_q.wp[0]};
				ADDR_ZSTATE: s_d.prdata = {16'h0000, 1'b0, s_q.zst[3], 1'b0, s_q.zst[2],
					1'b0, s_q.zst[1], 1'b0, s_q.zst[0]};
				ADDR_HOLD: s_d.prdata = {16'h0000, s_q.hold};
				default: s_d.prdata = 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_q <= REGS_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : cczm_top

//--- testbench/cczm_host.sv
`timescale 1ns/1ps
// ****
// host model, bus master
// ****
module cczm_host (
	input wire logic core_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : cczm_host

//--- testbench/cczm_props.sv
`timescale 1ns/1ps
// ****
// checker
// ****
module cczm_chk
	import cczm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic nonvolatile_cache_supported,
	input wire logic nv_power_degraded,
	input wire logic nv_cache_volatile,
	input wire logic act_valid,
	input wire logic [2:0] act_code,
	input wire logic [7:0] act_lba,
	input wire logic ie_valid,
	input wire logic [7:0] ie_code,
	input wire logic ua_pending,
	input wire logic [7:0] ua_code
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	sequence vol_rise;
		$rose(nv_cache_volatile) && nonvolatile_cache_supported;
	endsequence
	sequence deg_rise;
		$rose(nv_power_degraded) && !$rose(nv_cache_volatile) && nonvolatile_cache_supported;
	endsequence
	sequence hold_rd;
		nv_cache_volatile [*3] ##0 (psel && !penable && !pwrite && paddr == ADDR_HOLD);
	endsequence
	chk_vol_report: assert property (vol_rise |-> ##[1:2] (
		(ie_valid && ie_code == ASC_NOW_VOLATILE) || (ua_pending && ua_code == ASC_NOW_VOLATILE)))
		else $error("volatile event unreported");
	chk_deg_report: assert property (deg_rise |-> ##[1:2] (
		(ie_valid && ie_code == ASC_DEGRADED) || (ua_pending && ua_code == ASC_DEGRADED)))
		else $error("degraded event unreported");
	chk_boot_ua: assert property ($rose(rstn) && nonvolatile_cache_supported &&
		nv_cache_volatile |-> ##[1:2] (ua_pending && ua_code == ASC_NOW_VOLATILE))
		else $error("boot attention missing");
	chk_ie_pulse: assert property (ie_valid |=> !ie_valid)
		else $error("exception not a pulse");
	chk_ie_supported: assert property (ie_valid |-> nonvolatile_cache_supported)
		else $error("exception without support");
	chk_inv_then_write: assert property (act_valid && act_code == ACT_CACHE_INV |=>
		act_valid && act_code == ACT_MED_WR && act_lba == $past(act_lba))
		else $error("invalidate not followed by medium write");
	chk_hold_zero: assert property (hold_rd |=> prdata[15:0] == 16'h0000)
		else $error("hold time not zero");
	chk_ua_sticky: assert property (ua_pending && !(psel && penable && pwrite &&
		paddr == ADDR_STATUS && pwdata[STAT_UA_BIT]) |=> ua_pending)
		else $error("attention lost");
	chk_apb_ready: assert property (psel |-> pready == penable)
		else $error("ready wrong");
	chk_apb_error: assert property (psel && penable |->
		pslverr == (paddr > ADDR_HOLD || paddr[1:0] != 2'h0))
		else $error("slave error wrong");
endmodule : cczm_chk

bind cczm_top cczm_chk chk_u (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .nonvolatile_cache_supported, .nv_power_degraded,
	.nv_cache_volatile, .act_valid, .act_code, .act_lba, .ie_valid, .ie_code, .ua_pending,
	.ua_code);

//--- testbench/tb.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module tb
	import cczm_pkg::*;
;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic nonvolatile_cache_supported = 1'b1;
	logic nv_power_degraded = 1'b0;
	logic nv_cache_volatile = 1'b1;
	logic power_loss_recover = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, act_valid, ie_valid, ua_pending, busy;
	logic [7:0] paddr, act_lba, ie_code, ua_code, ie_last;
	logic [31:0] pwdata, prdata, r;
	logic [2:0] act_code;
	logic [10:0] acts[$];
	int errors = 0;
	int compares = 0;
	cczm_top dut_u (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .nonvolatile_cache_supported, .nv_power_degraded,
		.nv_cache_volatile, .power_loss_recover, .act_valid, .act_code, .act_lba,
		.ie_valid, .ie_code, .ua_pending, .ua_code, .busy);
	cczm_host host_u (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	initial forever #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (act_valid === 1'b1) acts.push_back({act_code, act_lba});
		if (ie_valid === 1'b1) ie_last = ie_code;
	end
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : ck
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		host_u.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		host_u.xfer(1'b0, a, 32'h0, q, e);
	endtask : rd
	task automatic act(input logic [2:0] c, input logic [7:0] l);
		logic [10:0] g;
		g = (acts.size() > 0) ? acts.pop_front() : 11'h7FF;
		ck({21'h0, g}, {21'h0, c, l});
	endtask : act
	task automatic cmd(input logic [3:0] op, input logic f, input logic [7:0] l);
		int n;
		ck(32'(acts.size()), 32'h0);
		wr(ADDR_CMD, {16'h0000, l, 3'h0, f, op});
		@(posedge core_clk);
		ck({31'h0, busy}, 32'h1);
		n = 0;
		do begin
			rd(ADDR_STATUS, r);
			n++;
		end while (r[0] !== 1'b0 && n < 200);
		ck({31'h0, r[0]}, 32'h0);
		ck({31'h0, busy}, 32'h0);
		repeat (2) @(posedge core_clk);
	endtask : cmd
	task automatic t_boot();
		logic e;
		rd(ADDR_STATUS, r);
		ck(r & 32'hFF20, 32'h0220);
		rd(ADDR_CTRL, r);
		ck(r, 32'h20);
		host_u.xfer(1'b0, 8'h18, 32'h0, r, e);
		ck({31'h0, e}, 32'h1);
		wr(ADDR_STATUS, 32'h20);
		nv_cache_volatile <= 1'b0;
	endtask : t_boot
	task automatic t_rw();
		cmd(OP_HOST_WR, 1'b0, 8'h05);
		act(ACT_CACHE_WR, 8'h05);
		cmd(OP_HOST_RD, 1'b0, 8'h05);
		act(ACT_CACHE_RD, 8'h05);
		cmd(OP_HOST_RD, 1'b0, 8'h06);
		act(ACT_MED_RD, 8'h06);
		cmd(OP_HOST_WR, 1'b0, 8'h05);
		act(ACT_CACHE_WR, 8'h05);
		cmd(OP_INT_WR, 1'b0, 8'h05);
		act(ACT_CACHE_INV, 8'h05);
		act(ACT_MED_WR, 8'h05);
		cmd(OP_HOST_WR, 1'b0, 8'h07);
		act(ACT_CACHE_WR, 8'h07);
		cmd(OP_INT_RD, 1'b0, 8'h07);
		act(ACT_MED_WR, 8'h07);
		act(ACT_MED_RD, 8'h07);
		cmd(OP_HOST_WR, 1'b0, 8'h08);
		act(ACT_CACHE_WR, 8'h08);
		cmd(OP_VERIFY, 1'b0, 8'h08);
		act(ACT_MED_WR, 8'h08);
		act(ACT_MED_VFY, 8'h08);
		cmd(OP_VERIFY, 1'b0, 8'h08);
		act(ACT_MED_VFY, 8'h08);
		rd(ADDR_WPTR, r);
		ck(r & 32'h7F, 32'h09);
	endtask : t_rw
	task automatic t_evt();
		wr(ADDR_CTRL, 32'h21);
		nv_power_degraded <= 1'b1;
		repeat (3) @(posedge core_clk);
		ck({24'h0, ie_last}, 32'h01);
		nv_cache_volatile <= 1'b1;
		repeat (3) @(posedge core_clk);
		ck({24'h0, ie_last}, 32'h02);
		wr(ADDR_HOLD, 32'h1234);
		rd(ADDR_HOLD, r);
		ck(r & 32'hFFFF, 32'h0);
		cmd(OP_HOST_WR, 1'b1, 8'h10);
		act(ACT_CACHE_INV, 8'h10);
		act(ACT_MED_WR, 8'h10);
		wr(ADDR_CTRL, 32'h20);
		nv_power_degraded <= 1'b0;
		nv_cache_volatile <= 1'b0;
		repeat (2) @(posedge core_clk);
		nv_power_degraded <= 1'b1;
		rd(ADDR_STATUS, r);
		ck(r & 32'hFF20, 32'h0120);
		wr(ADDR_STATUS, 32'h20);
		nv_cache_volatile <= 1'b1;
		rd(ADDR_STATUS, r);
		ck(r & 32'hFF20, 32'h0220);
		wr(ADDR_STATUS, 32'h20);
		nv_cache_volatile <= 1'b0;
	endtask : t_evt
	task automatic t_zone();
		cmd(OP_HOST_WR, 1'b0, 8'h80);
		act(ACT_CACHE_WR, 8'h80);
		cmd(OP_HOST_WR, 1'b1, 8'h82);
		act(ACT_MED_WR, 8'h80);
		act(ACT_CACHE_WR, 8'h82);
		cmd(OP_CLOSE, 1'b0, 8'h80);
		act(ACT_MED_WR, 8'h82);
		cmd(OP_MGMT, 1'b0, 8'h00);
		rd(ADDR_ZSTATE, r);
		ck(r, 32'h0301);
		cmd(OP_OPEN, 1'b0, 8'h40);
		cmd(OP_MGMT, 1'b0, 8'h00);
		rd(ADDR_STATUS, r);
		ck(r & 32'h4, 32'h0);
		rd(ADDR_ZSTATE, r);
		ck(r, 32'h0323);
		cmd(OP_OPEN, 1'b0, 8'hC0);
		cmd(OP_MGMT, 1'b0, 8'h00);
		rd(ADDR_STATUS, r);
		ck(r & 32'hFF0004, 32'h030004);
	endtask : t_zone
	task automatic t_loss();
		nv_cache_volatile <= 1'b1;
		cmd(OP_HOST_WR, 1'b0, 8'hC3);
		act(ACT_CACHE_WR, 8'hC3);
		power_loss_recover <= 1'b1;
		@(posedge core_clk);
		power_loss_recover <= 1'b0;
		rd(ADDR_WPTR, r);
		ck({25'h0, r[30:24]}, 32'h3);
	endtask : t_loss
	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		#300000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		t_boot();
		t_rw();
		t_evt();
		t_zone();
		t_loss();
		tally_and_finish();
	end
endmodule : tb
